/* File: src/gcomp_map.vh */
// Constants for the gauge compensation engine and single-wire host port
`ifndef GCOMP_MAP_VH
`define GCOMP_MAP_VH
// -----------------------------------------------------------------
// Register addresses (7-bit)
// -----------------------------------------------------------------
`define GCOMP_ADDR_TEMP      7'h02
`define GCOMP_ADDR_CHGH      7'h03
`define GCOMP_ADDR_CHGL      7'h17
`define GCOMP_ADDR_ID        7'h04
`define GCOMP_ADDR_CAP       7'h05
`define GCOMP_ADDR_FLAGS     7'h01
`define GCOMP_ADDR_INACC     7'h09
`define GCOMP_ADDR_FILT      7'h0a
// -----------------------------------------------------------------
// Field positions and reset values
// -----------------------------------------------------------------
`define GCOMP_CMD_DIR_BIT    7
`define GCOMP_FLAG_DOUBT_BIT 4
`define GCOMP_FILT_RESET     8'h96
`define GCOMP_INACC_MAX      8'hff
`define GCOMP_DOUBT_COUNT    8'h40
// Compensation factors in hundredths
`define GCOMP_FACT_UNITY     8'h64
`define GCOMP_FACT_STEP      8'h05
`define GCOMP_LOWT_MAX       3'h4
// Sense threshold for the high-rate factor, in microvolts
`define GCOMP_HIRATE_UV      (-150000)
// Filter numerator in microvolts, charge threshold ratio *4
`define GCOMP_FILT_NUM_UV    45000
`define GCOMP_NOMINAL_BAND   3'h2
// -----------------------------------------------------------------
// Serial timing in microseconds, clock in MHz
// -----------------------------------------------------------------
`define GCOMP_CLK_MHZ        25
`define GCOMP_BREAK_US       190
`define GCOMP_SAMPLE_US      1500
`define GCOMP_START_US       500
`define GCOMP_SETUP_US       500
`define GCOMP_STOPSU_US      2000
`define GCOMP_BIT_US         3000
`endif

/* File: src/gcomp_bit_timer.v */
// Restartable cycle counter used for break and bit-frame phases
`timescale 1ns/1ps
module gcomp_bit_timer #(
   parameter W = 18
) (
   input  wire         ref_clk,
   input  wire         rst,
   input  wire         restart,
   output reg  [W-1:0] count
);
   always @(posedge ref_clk) begin
      if (rst || restart) begin
         count <= {W{1'b0}};
      end else if (count != {W{1'b1}}) begin
         count <= count + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: src/gcomp_sat_counter.v */
// Saturating counter with clear; clear wins over an increment
`timescale 1ns/1ps
module gcomp_sat_counter #(
   parameter W = 8
) (
   input  wire         ref_clk,
   input  wire         rst,
   input  wire         clear,
   input  wire         inc,
   output reg  [W-1:0] count
);
   always @(posedge ref_clk) begin
      if (rst || clear) begin
         count <= {W{1'b0}};
      end else if (inc && count != {W{1'b1}}) begin
         count <= count + {{(W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: src/gcomp_engine.v */
// Count compensation engine and single-wire host serial port
//
// Summary of operation
// - Discharge factor 1.05 below -150 mV sense
// - Add 0.05 per 10C band below 10C, for sense between -150 mV and 0
// - Cold step count saturates at four, 1.20
// - Nominal self-discharge count/64 or count/47 selectable
// - Eight bands, rate doubles per warmer band
// - Drop counts inside the filter dead band
// - Discharge threshold -45/divisor, charge -1.25 times
// - Filter divisor resets to 150
// - Inaccuracy counter counts charges, clears on reload without a charge
// - Inaccuracy counter saturates at 255
// - Doubt flag after 64 charges without reload
// - Pin only pulled low or released
// - Command byte then write or read byte
// - Bit rate no faster than 333 bits/s
// - Bytes sent eight bits, LSB first
// - Break then recovery opens a command
// - Low start, data by setup, held valid
// - Release high by stop setup, recover
// - Top command bit is direction, seven address
// - Writes to unwritable addresses ignored
`timescale 1ns/1ps
`include "gcomp_map.vh"
module gcomp_engine #(
   parameter BREAK_CYC  = `GCOMP_BREAK_US * `GCOMP_CLK_MHZ,
   parameter SAMPLE_CYC = `GCOMP_SAMPLE_US * `GCOMP_CLK_MHZ,
   parameter START_CYC  = `GCOMP_START_US * `GCOMP_CLK_MHZ,
   parameter SETUP_CYC  = `GCOMP_SETUP_US * `GCOMP_CLK_MHZ,
   parameter STOP_CYC   = `GCOMP_STOPSU_US * `GCOMP_CLK_MHZ,
   parameter BIT_CYC    = `GCOMP_BIT_US * `GCOMP_CLK_MHZ
) (
   input  wire               ref_clk,
   input  wire               rst,
   input  wire signed [31:0] senseUv,
   input  wire signed [31:0] offsetUv,
   input  wire signed [7:0]  tempC,
   input  wire               countStrobe,
   input  wire               selfDischargeSelect,
   input  wire               validCharge,
   input  wire               capacityReload,
   input  wire [15:0]        availableCharge,
   input  wire [7:0]         temperatureGauge,
   input  wire [7:0]         flagsIn,
   input  wire               serialIn,
   output reg  [7:0]         compFactor,
   output reg  [2:0]         lowTempSteps,
   output reg                countPass,
   output reg                countIsCharge,
   output reg  [15:0]        selfDischargeDivisor,
   output reg  [7:0]         filterDivisor,
   output reg  signed [31:0] dischargeThresholdUv,
   output reg  signed [31:0] chargeThresholdUv,
   output wire [7:0]         capacityInaccuracy,
   output reg                capacityDoubt,
   output reg  [7:0]         batteryId,
   output reg  [7:0]         capacityWrite,
   output reg                capacityWriteStrobe,
   output reg  [7:0]         chargeWrite,
   output reg                chargeWriteStrobe,
   output reg                serialOut,
   output reg                serialOe
);
   // -----------------------------------------------------------------
   // Compensation
   // -----------------------------------------------------------------
   localparam signed [31:0] HIRATE = `GCOMP_HIRATE_UV;
   wire signed [31:0] corrected = senseUv + offsetUv;
   reg  [2:0] next_steps;
   reg  [2:0] band;
   wire [15:0] baseDiv = selfDischargeSelect ? 16'h002f : 16'h0040;
   always @* begin
      if (tempC >= 8'sd10) next_steps = 3'h0;
      else if (tempC >= 8'sd0) next_steps = 3'h1;
      else if (tempC >= -8'sd10) next_steps = 3'h2;
      else if (tempC >= -8'sd20) next_steps = 3'h3;
      else next_steps = `GCOMP_LOWT_MAX;
      if (tempC < 8'sd10) band = 3'h0;
      else if (tempC >= 8'sd70) band = 3'h7;
      else band = band_of(tempC);
   end
   function [2:0] band_of;
      input signed [7:0] t;
      reg [7:0] q;
      begin
         q = t / 8'sd10;
         band_of = q[2:0];
      end
   endfunction
   always @(posedge ref_clk) begin
      if (rst) begin
         compFactor <= `GCOMP_FACT_UNITY;
         lowTempSteps <= 3'h0;
         selfDischargeDivisor <= 16'h0040;
         dischargeThresholdUv <= 32'sd0;
         chargeThresholdUv <= 32'sd0;
         countPass <= 1'b0;
         countIsCharge <= 1'b0;
      end else begin
         lowTempSteps <= next_steps;
         if (senseUv < HIRATE) begin
            compFactor <= `GCOMP_FACT_UNITY + `GCOMP_FACT_STEP;
         end else if (senseUv < 32'sd0) begin
            compFactor <= `GCOMP_FACT_UNITY
                          + {5'h0, next_steps} * `GCOMP_FACT_STEP;
         end else begin
            compFactor <= `GCOMP_FACT_UNITY;
         end
         // Divisor halves per warmer band, doubles per cooler one
         if (band < `GCOMP_NOMINAL_BAND) begin
            selfDischargeDivisor <= baseDiv << (`GCOMP_NOMINAL_BAND - band);
         end else begin
            selfDischargeDivisor <= baseDiv >> (band - `GCOMP_NOMINAL_BAND);
         end
         // Scaled by 100 then divided back; both divides run every cycle
         dischargeThresholdUv <= -($signed(`GCOMP_FILT_NUM_UV * 100)
                                 / $signed({24'h0, filterDivisor}) / 100);
         chargeThresholdUv <= ($signed(`GCOMP_FILT_NUM_UV * 5)
                              / $signed({24'h0, filterDivisor})) / 4;
         countPass <= countStrobe && (corrected < dischargeThresholdUv
                                   || corrected > chargeThresholdUv);
         countIsCharge <= corrected > chargeThresholdUv;
      end
   end
   // -----------------------------------------------------------------
   // Capacity inaccuracy
   // -----------------------------------------------------------------
   gcomp_sat_counter #(.W(8)) inaccCounter (
      .ref_clk (ref_clk),
      .rst     (rst),
      .clear   (capacityReload && !validCharge),
      .inc     (validCharge),
      .count   (capacityInaccuracy)
   );
   always @(posedge ref_clk) begin
      if (rst) begin
         capacityDoubt <= 1'b1;
      end else if (capacityInaccuracy >= `GCOMP_DOUBT_COUNT) begin
         capacityDoubt <= 1'b1;
      end else if (capacityReload) begin
         capacityDoubt <= 1'b0;
      end
   end
   // -----------------------------------------------------------------
   // Serial port
   // -----------------------------------------------------------------
   localparam S_IDLE  = 3'h0;
   localparam S_BRK   = 3'h1;
   localparam S_CMD   = 3'h2;
   localparam S_WDAT  = 3'h3;
   localparam S_TX    = 3'h4;
   reg        sync1;
   reg        sync2;
   reg        prevLine;
   reg [2:0]  state;
   reg [7:0]  shift;
   reg [2:0]  bitNum;
   reg [6:0]  addr;
   reg        sampled;
   reg [7:0]  readValue;
   reg        txRun;
   reg [17:0] txCount;
   wire [17:0] phase;
   wire       fall = prevLine && !sync2;
   gcomp_bit_timer #(.W(18)) phaseTimer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .restart (fall),
      .count   (phase)
   );
   always @* begin
      case (addr)
         `GCOMP_ADDR_FLAGS: readValue = {flagsIn[7:5], capacityDoubt, flagsIn[3:0]};
         `GCOMP_ADDR_TEMP:  readValue = temperatureGauge;
         `GCOMP_ADDR_CHGH:  readValue = availableCharge[15:8];
         `GCOMP_ADDR_CHGL:  readValue = availableCharge[7:0];
         `GCOMP_ADDR_ID:    readValue = batteryId;
         `GCOMP_ADDR_INACC: readValue = capacityInaccuracy;
         `GCOMP_ADDR_FILT:  readValue = filterDivisor;
         default:           readValue = 8'h00;
      endcase
   end
   always @(posedge ref_clk) begin
      if (rst) begin
         sync1 <= 1'b1;
         sync2 <= 1'b1;
         prevLine <= 1'b1;
         state <= S_IDLE;
         shift <= 8'h00;
         bitNum <= 3'h0;
         addr <= 7'h00;
         sampled <= 1'b0;
         txRun <= 1'b0;
         txCount <= 18'h0;
         serialOut <= 1'b0;
         serialOe <= 1'b0;
         filterDivisor <= `GCOMP_FILT_RESET;
         batteryId <= 8'h00;
         capacityWrite <= 8'h00;
         capacityWriteStrobe <= 1'b0;
         chargeWrite <= 8'h00;
         chargeWriteStrobe <= 1'b0;
      end else begin
         sync1 <= serialIn;
         sync2 <= sync1;
         prevLine <= sync2;
         capacityWriteStrobe <= 1'b0;
         chargeWriteStrobe <= 1'b0;
         serialOut <= 1'b0;
         if (fall) sampled <= 1'b0;
         case (state)
            S_IDLE: begin
               // A low longer than break time, then release
               if (!sync2 && phase >= BREAK_CYC) state <= S_BRK;
            end
            S_BRK: begin
               if (sync2) begin
                  state <= S_CMD;
                  bitNum <= 3'h0;
               end
            end
            S_CMD, S_WDAT: begin
               if (!sync2 && phase >= BREAK_CYC * 10) begin
                  state <= S_BRK;
               end else if (!sampled && phase == SAMPLE_CYC) begin
                  sampled <= 1'b1;
                  shift <= {sync2, shift[7:1]};
                  bitNum <= bitNum + 3'h1;
                  if (bitNum == 3'h7 && state == S_CMD) begin
                     addr <= shift[7:1];
                     if (sync2) begin
                        state <= S_WDAT;
                     end else begin
                        state <= S_TX;
                     end
                  end else if (bitNum == 3'h7) begin
                     // Each transaction is opened by its own break
                     state <= S_IDLE;
                     case (addr)
                        `GCOMP_ADDR_CHGH: begin
                           chargeWrite <= {sync2, shift[7:1]};
                           chargeWriteStrobe <= 1'b1;
                        end
                        `GCOMP_ADDR_ID:   batteryId <= {sync2, shift[7:1]};
                        `GCOMP_ADDR_CAP: begin
                           capacityWrite <= {sync2, shift[7:1]};
                           capacityWriteStrobe <= 1'b1;
                        end
                        `GCOMP_ADDR_FILT: filterDivisor <= {sync2, shift[7:1]};
                        default: ;
                     endcase
                  end
               end
            end
            S_TX: begin
               // Own counter: our own falls would restart the phase timer
               if (!txRun) begin
                  // Wait out the host's last command frame first
                  if (phase >= BIT_CYC) begin
                     txRun <= 1'b1;
                     txCount <= 18'h0;
                     bitNum <= 3'h0;
                  end
               end else begin
                  // Device-driven frame paced at one bit per BIT_CYC
                  txCount <= txCount + 18'h1;
                  if (txCount < START_CYC) begin
                     serialOe <= 1'b1;
                  end else if (txCount < STOP_CYC) begin
                     serialOe <= !readValue[bitNum];
                  end else begin
                     serialOe <= 1'b0;
                  end
                  if (txCount == BIT_CYC - 1) begin
                     txCount <= 18'h0;
                     bitNum <= bitNum + 3'h1;
                     if (bitNum == 3'h7) begin
                        state <= S_IDLE;
                        txRun <= 1'b0;
                     end
                  end
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

/* File: bench/gcomp_engine_props.sv */
// Port-level assertions for the compensation engine
`timescale 1ns/1ps
module gcomp_engine_props (
   input wire               ref_clk,
   input wire               rst,
   input wire signed [31:0] senseUv,
   input wire signed [31:0] offsetUv,
   input wire signed [7:0]  tempC,
   input wire               countStrobe,
   input wire               validCharge,
   input wire               capacityReload,
   input wire [7:0]         compFactor,
   input wire [2:0]         lowTempSteps,
   input wire               countPass,
   input wire signed [31:0] dischargeThresholdUv,
   input wire signed [31:0] chargeThresholdUv,
   input wire [7:0]         capacityInaccuracy,
   input wire               serialOut,
   input wire               serialOe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   // Inputs held three samples so pipeline latency cannot matter
   property p_rate_hi;
      (senseUv < -150000 && $stable(senseUv) && $stable(tempC))[*3] |-> compFactor == 8'h69;
   endproperty
   a_rate_hi: assert property (p_rate_hi) else $error("high-rate factor wrong");
   property p_cold;
      (senseUv > -150000 && senseUv < 0 && $stable(senseUv) && $stable(tempC))[*3]
         |-> compFactor == 8'h64 + 8'h05 * lowTempSteps;
   endproperty
   a_cold: assert property (p_cold) else $error("cold factor wrong");
   property p_steps_max;
      lowTempSteps <= 3'h4;
   endproperty
   a_steps_max: assert property (p_steps_max) else $error("cold steps above four");
   property p_pass_cause;
      countPass |-> $past(countStrobe);
   endproperty
   a_pass_cause: assert property (p_pass_cause) else $error("count passed unprompted");
   property p_dead_band;
      countStrobe && senseUv + offsetUv > dischargeThresholdUv
         && senseUv + offsetUv < chargeThresholdUv |=> !countPass;
   endproperty
   a_dead_band: assert property (p_dead_band) else $error("dead-band count passed");
   property p_inacc_inc;
      validCharge && !capacityReload && capacityInaccuracy != 8'hff
         |=> capacityInaccuracy == $past(capacityInaccuracy) + 8'h01;
   endproperty
   a_inacc_inc: assert property (p_inacc_inc) else $error("charge not counted");
   property p_inacc_clr;
      capacityReload && !validCharge |=> capacityInaccuracy == 8'h00;
   endproperty
   a_inacc_clr: assert property (p_inacc_clr) else $error("reload did not clear");
   property p_inacc_sat;
      capacityInaccuracy == 8'hff && !capacityReload |=> capacityInaccuracy == 8'hff;
   endproperty
   a_inacc_sat: assert property (p_inacc_sat) else $error("counter wrapped");
   property p_pin_low;
      serialOe |-> !serialOut;
   endproperty
   a_pin_low: assert property (p_pin_low) else $error("pin driven high");
endmodule
bind gcomp_engine gcomp_engine_props chk_u (.ref_clk, .rst, .senseUv, .offsetUv, .tempC,
   .countStrobe, .validCharge, .capacityReload, .compFactor, .lowTempSteps, .countPass,
   .dischargeThresholdUv, .chargeThresholdUv, .capacityInaccuracy, .serialOut, .serialOe);

/* File: bench/gcomp_host_model.sv */
// Host processor model for the single-wire serial port
`timescale 1ns/1ps
module gcomp_host_model #(
   parameter BRK = 20,
   parameter ST  = 5,
   parameter SU  = 20,
   parameter BIT = 30,
   parameter SMP = 15
) (
   input  wire        ref_clk,
   input  wire        line,
   output logic       hostLow,
   output logic [7:0] readByte,
   output logic       readDone
);
   initial begin
      hostLow = 0;
      readByte = 8'h00;
      readDone = 0;
   end
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // Only pulls low; the pull-up sits on the wire itself
   task automatic send_bit(input logic b);
      hostLow = 1;
      idle(b ? ST : SU);
      hostLow = 0;
      idle(b ? BIT - ST : BIT - SU); // Frame length sets the scaled bit rate
   endtask
   task automatic access(input logic [7:0] cmd, input logic [7:0] data);
      logic [7:0] v;
      int         n;
      hostLow = 1;
      idle(BRK + 4);
      hostLow = 0;
      idle(BIT);
      for (int i = 0; i < 8; i++) send_bit(cmd[i]);
      if (cmd[7]) begin
         for (int i = 0; i < 8; i++) send_bit(data[i]);
      end else begin
         n = 0;
         for (int i = 0; i < 8; i++) begin
            while (line && n < 16 * BIT) begin idle(1); n++; end
            idle(SMP);
            v[i] = line;
            while (!line && n < 16 * BIT) begin idle(1); n++; end
         end
         readByte = v;
         readDone = 1;
         idle(1);
         readDone = 0;
      end
      idle(BIT);
   endtask
endmodule

/* File: bench/gcomp_engine_test.sv */
// Self-checking bench for the compensation engine and host port
`timescale 1ns/1ps
`include "gcomp_map.vh"
module gcomp_engine_test;
   localparam BRK = 20, SMP = 15, ST = 5, SU = 20, BIT = 30;
   logic ref_clk = 0, rst = 1, countStrobe = 0, selfDischargeSelect = 0;
   logic validCharge = 0, capacityReload = 0, d1 = 0;
   logic signed [31:0] senseUv = 0, offsetUv = 0;
   logic signed [7:0]  tempC = 25;
   wire [7:0] compFactor, filterDivisor, capacityInaccuracy, readByte;
   wire [2:0] lowTempSteps;
   wire [15:0] selfDischargeDivisor;
   wire signed [31:0] dischargeThresholdUv, chargeThresholdUv;
   wire countPass, countIsCharge, capacityDoubt, serialOe, hostLow, readDone;
   wire [7:0] batteryId, capWr, chgWr;
   wire capStb, chgStb;
   logic [7:0] qWr[$];
   wire line = !(hostLow || serialOe); // Pull-up wins when nobody pulls low
   int miscompares = 0, testsRun = 0, cycles = 0, seed, d;
   logic [1:0] qCount[$];
   logic [7:0] qRead[$];
   logic [7:0] id;
   int tTemp[8] = '{25, 15, 5, -5, -15, -25, -40, 55};
   int tSteps[8] = '{0, 0, 1, 2, 3, 4, 4, 0};
   int tDiv[8] = '{64, 128, 256, 256, 256, 256, 256, 8};
   int tDiv47[3] = '{47, 94, 188};
   int tSum[5] = '{0, -299, 374, 376, -301};
   logic [1:0] tExp[5] = '{2'b00, 2'b00, 2'b00, 2'b11, 2'b10};
   int tDmf[4] = '{75, 90, 125, 225};
   always #20 ref_clk = ~ref_clk;
   gcomp_engine #(.BREAK_CYC(BRK), .SAMPLE_CYC(SMP), .START_CYC(ST), .SETUP_CYC(5),
      .STOP_CYC(SU), .BIT_CYC(BIT)) dut_u (.ref_clk, .rst, .senseUv, .offsetUv, .tempC,
      .countStrobe, .selfDischargeSelect, .validCharge, .capacityReload,
      .availableCharge(16'h1234), .temperatureGauge(8'h61), .flagsIn(8'h00), .serialIn(line),
      .compFactor, .lowTempSteps, .countPass, .countIsCharge, .selfDischargeDivisor,
      .filterDivisor, .dischargeThresholdUv, .chargeThresholdUv, .capacityInaccuracy,
      .capacityDoubt, .batteryId, .capacityWrite(capWr), .capacityWriteStrobe(capStb),
      .chargeWrite(chgWr), .chargeWriteStrobe(chgStb), .serialOut(), .serialOe);
   gcomp_host_model #(.BRK(BRK), .ST(ST), .SU(SU), .BIT(BIT), .SMP(SMP)) host_u (.ref_clk,
      .line, .hostLow, .readByte, .readDone);
   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // Count result lands one cycle after the strobe
   always @(posedge ref_clk) begin
      d1 <= countStrobe;
      cycles <= cycles + 1;
      if (d1 && qCount.size() > 0) check({countPass, countPass & countIsCharge}, qCount.pop_front());
      if ((capStb || chgStb) && qWr.size() > 0) check(capStb ? capWr : chgWr, qWr.pop_front());
      if (cycles == 30000) begin
         miscompares++;
         end_of_test();
      end
   end
   always @(posedge readDone) if (qRead.size() > 0) check(readByte, qRead.pop_front());
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      seed = $urandom(32'h6ce75b0b);
      tick(12);
      rst = 0;
      tick(2);
      check(filterDivisor, 150);
      check(dischargeThresholdUv, -300);
      check(chargeThresholdUv, 375);
      check({capacityDoubt, capacityInaccuracy, serialOe}, 10'h200);
      for (int i = 0; i < 8; i++) begin
         tempC = tTemp[i];
         senseUv = (i == 0) ? -200000 : -1000;
         selfDischargeSelect = 0;
         tick(4);
         check(compFactor, (i == 0) ? 105 : 100 + 5 * tSteps[i]);
         check(lowTempSteps, tSteps[i]);
         check(selfDischargeDivisor, tDiv[i]);
         if (i < 3) begin
            selfDischargeSelect = 1;
            tick(4);
            check(selfDischargeDivisor, tDiv47[i]);
         end
      end
      for (int i = 0; i < 5; i++) begin
         offsetUv = int'($urandom_range(2000)) - 1000;
         senseUv = tSum[i] - offsetUv;
         countStrobe = 1;
         qCount.push_back(tExp[i]);
         tick(1);
         countStrobe = 0;
         tick(3);
      end
      d = tDmf[$urandom_range(3)];
      host_u.access({1'b1, `GCOMP_ADDR_FILT}, d[7:0]);
      tick(4);
      check(filterDivisor, d);
      check(dischargeThresholdUv, -45000 / d);
      check(chargeThresholdUv, 45000 * 5 / (4 * d));
      id = $urandom;
      host_u.access({1'b1, `GCOMP_ADDR_ID}, id);
      check(batteryId, id);
      qRead.push_back(id);
      host_u.access({1'b0, `GCOMP_ADDR_ID}, 8'h00);
      host_u.access({1'b1, `GCOMP_ADDR_INACC}, 8'h5a);
      tick(4);
      check({capacityInaccuracy, filterDivisor}, {8'h00, d[7:0]});
      d = $urandom_range(255);
      qWr.push_back(d[7:0]);
      host_u.access({1'b1, `GCOMP_ADDR_CAP}, d[7:0]);
      qWr.push_back(~d[7:0]);
      host_u.access({1'b1, `GCOMP_ADDR_CHGH}, ~d[7:0]);
      capacityReload = 1;
      tick(1);
      capacityReload = 0;
      tick(3);
      check({capacityDoubt, capacityInaccuracy}, 0);
      for (int i = 1; i <= 300; i++) begin
         validCharge = 1;
         tick(1);
         validCharge = 0;
         tick(1);
         if (i == 63 || i == 64) begin
            tick(3);
            check(capacityDoubt, i == 64);
         end
      end
      check(capacityInaccuracy, 8'hff);
      qRead.push_back(8'hff);
      host_u.access({1'b0, `GCOMP_ADDR_INACC}, 8'h00);
      tick(10);
      check(qRead.size() + qWr.size(), 0);
      end_of_test();
   end
endmodule
